// ---- dv/cht_crt_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module cht_crt_monitor (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        syncPin,
  input  wire logic        de,
  input  wire logic        blank,
  input  wire logic        activeHigh,
  output logic      [15:0] activeLen,
  output logic      [15:0] blankLen,
  output logic      [15:0] syncOfs,
  output logic      [15:0] syncLen
);
  logic [15:0] deCnt;
  logic [15:0] blCnt;
  logic [15:0] syCnt;
  logic        syncOn;
  assign syncOn = (syncPin == activeHigh);
  // Lengths latch on trailing edges, so they lag by one period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {deCnt, blCnt, syCnt} <= '0;
      {activeLen, blankLen, syncOfs, syncLen} <= '0;
    end else begin
      deCnt <= de ? deCnt + 16'h1 : 16'h0;
      blCnt <= blank ? blCnt + 16'h1 : 16'h0;
      syCnt <= syncOn ? syCnt + 16'h1 : 16'h0;
      if (!de && deCnt != 16'h0)
        activeLen <= deCnt;
      if (!blank && blCnt != 16'h0)
        blankLen <= blCnt;
      if (syncOn && syCnt == 16'h0)
        syncOfs <= blCnt;
      if (!syncOn && syCnt != 16'h0)
        syncLen <= syCnt;
    end
  end
endmodule : cht_crt_monitor
`default_nettype wire

// ---- dv/cht_horiz_timing_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module cht_horiz_timing_properties
  import cht_pkg::*;
#(
  parameter int CNT_W = CNT_W_DEF
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic              wrStrobe,
  input wire logic              rdStrobe,
  input wire logic [DATA_W-1:0] rdData,
  input wire logic              horizontalSyncOut,
  input wire logic              displayEnable,
  input wire logic              blankActive,
  input wire logic              lineStart
);
  logic polR;
  logic syncOn;
  // Polarity shadow from bus writes; the pin alone cannot tell it
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      polR <= 1'b0;
    else if (wrStrobe && addr == OFS_SYNC_WID_POL)
      polR <= wrData[SYNC_POL_BIT];
  end
  assign syncOn = (horizontalSyncOut == polR);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_DE_NOT_BLANK: assert property (
    !(displayEnable && blankActive)) else $error("active and blank overlap");
  AST_START_THEN_DE: assert property (
    lineStart |=> displayEnable) else $error("no active after line start");
  AST_START_NOT_DE: assert property (
    lineStart |-> !displayEnable) else $error("line start inside active");
  AST_BLANK_MIN: assert property (
    $rose(blankActive) |-> blankActive[*6]) else $error("blank too short");
  // Polarity held four cycles so a fresh write settles first
  AST_SYNC_IN_BLANK: assert property (
    (syncOn && polR == $past(polR, 4)) |-> blankActive)
    else $error("sync outside blank");
  AST_RD_IDLE: assert property (
    !$past(rdStrobe) |-> rdData == 8'h00) else $error("read data not idle");
  AST_RD_WIDTH_F: assert property (
    (rdStrobe && addr == OFS_ACTIVE_WIDTH) |=> !rdData[7])
    else $error("width field too wide");
  AST_RD_BLANK_F: assert property (
    (rdStrobe && addr == OFS_BLANK_PERIOD) |=> rdData[7:6] == 2'h0)
    else $error("blank field too wide");
  AST_RD_START_F: assert property (
    (rdStrobe && addr == OFS_SYNC_START) |=> rdData[7:6] == 2'h0)
    else $error("start field too wide");
  AST_RD_POL_F: assert property (
    (rdStrobe && addr == OFS_SYNC_WID_POL) |=> rdData[6:4] == 3'h0)
    else $error("sync width field too wide");
endmodule : cht_horiz_timing_properties
bind cht_horiz_timing cht_horiz_timing_properties #(.CNT_W(CNT_W)) u_props (
  .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
  .rdStrobe(rdStrobe), .rdData(rdData),
  .horizontalSyncOut(horizontalSyncOut), .displayEnable(displayEnable),
  .blankActive(blankActive), .lineStart(lineStart));
`default_nettype wire

// ---- dv/cht_horiz_timing_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module cht_horiz_timing_tb_top
  import cht_pkg::*;
;
  logic        clk, rst, wrStrobe, rdStrobe, polSel;
  logic [7:0]  addr, wrData, rdData;
  logic        hSync, de, blank, lineStart;
  logic [15:0] activeLen, blankLen, syncOfs, syncLen;
  int          errors, n_tests, cycles;

  cht_horiz_timing #(.CNT_W(CNT_W_DEF)) dut (.clk(clk), .rst(rst),
    .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData(rdData), .horizontalSyncOut(hSync), .displayEnable(de),
    .blankActive(blank), .lineStart(lineStart));
  cht_crt_monitor u_mon (.clk(clk), .rst(rst), .syncPin(hSync), .de(de),
    .blank(blank), .activeHigh(polSel), .activeLen(activeLen),
    .blankLen(blankLen), .syncOfs(syncOfs), .syncLen(syncLen));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
      input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 d = rdData;
  endtask : rd

  task automatic wait_ls();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (lineStart !== 1'b1 && k < 4000);
    chk(16'(k < 4000), 16'h1, "line start seen");
  endtask : wait_ls

  task automatic t_regs();
    logic [7:0] d;
    logic [7:0] ofs [5];
    logic [7:0] msk [5];
    ofs = '{OFS_ACTIVE_WIDTH, OFS_CONTROL, OFS_BLANK_PERIOD, OFS_SYNC_START,
      OFS_SYNC_WID_POL};
    msk = '{8'h7f, 8'h0f, 8'h3f, 8'h3f, 8'h8f};
    for (int i = 0; i < 5; i++) begin
      rd(ofs[i], d);
      chk(16'(d), 16'h0, "reset value");
      wr(ofs[i], 8'hff);
      rd(ofs[i], d);
      chk(16'(d), 16'(msk[i]), "field mask");
      wr(ofs[i], 8'h00);
    end
    wr(8'h4f, 8'hff);
    rd(8'h4f, d);
    chk(16'(d), 16'h0, "unmapped read");
    $display("test regs done");
  endtask : t_regs

  task automatic t_line(input logic [3:0] ctl, input logic [6:0] w,
      input logic [5:0] p, input logic [5:0] s, input logic [3:0] q,
      input logic pol);
    int a, b, st, sw;
    logic [7:0] d;
    a = (int'(w) + 1) * 8;
    sw = (int'(q) + 1) * 8;
    if (!ctl[CTRL_TV_BIT]) begin
      b = (int'(p) + 1) * 8;
      st = int'(s) * 8 + (ctl[CTRL_DEEP_BIT] ? 5 : 3);
    end else begin
      b = int'(p) * 8 + (ctl[CTRL_PAL_BIT] ? 7 : 6);
      st = (int'(s) + 1) * 8 - (ctl[CTRL_DEEP_BIT] ? 5 : 7);
    end
    polSel <= pol;
    wr(OFS_ACTIVE_WIDTH, {1'b0, w});
    wr(OFS_BLANK_PERIOD, {2'b00, p});
    wr(OFS_SYNC_START, {2'b00, s});
    wr(OFS_SYNC_WID_POL, {pol, 3'b000, q});
    // Mode bits settle through the span calculator before the first line
    wr(OFS_CONTROL, {4'h0, ctl});
    repeat (4) @(posedge clk);
    wr(OFS_CONTROL, {4'h0, ctl} | 8'h01);
    repeat (3) wait_ls();
    chk(activeLen, 16'(a), "active length");
    chk(blankLen, 16'(b), "blank length");
    chk(syncOfs, 16'(st), "sync start");
    chk(syncLen, 16'(sw), "sync width");
    // Read lands three cycles into the active period
    rd(OFS_STATUS, d);
    chk(16'(d), 16'h04, "status running");
    rd(OFS_POS_LOW, d);
    chk(16'(d), 16'h04, "pixel position");
    // Stop inside the active period so no blank is cut short
    wait_ls();
    wr(OFS_CONTROL, 8'h00);
    repeat (4) @(posedge clk);
    chk(16'({de, blank, hSync}), 16'({2'b00, ~pol}), "idle");
    rd(OFS_STATUS, d);
    chk(16'(d), 16'h00, "status idle");
    $display("test line done ctl %0h", ctl);
  endtask : t_line

  task automatic finish_test();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      finish_test();
    end
  end

  initial begin
    {wrStrobe, rdStrobe, polSel, addr, wrData} = '0;
    {errors, n_tests, cycles} = '0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    // Blank field kept at 3 or more in CRT; sync fits inside blank
    t_line(4'h0, 7'h00, 6'h03, 6'h00, 4'h0, 1'b1);
    t_line(4'h8, 7'h02, 6'h05, 6'h01, 4'h1, 1'b0);
    t_line(4'h0, 7'h7f, 6'h3f, 6'h2f, 4'hf, 1'b1);
    // TV modes: polarity and width fields held at zero
    t_line(4'h2, 7'h01, 6'h02, 6'h00, 4'h0, 1'b0);
    t_line(4'ha, 7'h01, 6'h02, 6'h00, 4'h0, 1'b0);
    t_line(4'h6, 7'h00, 6'h02, 6'h00, 4'h0, 1'b0);
    t_line(4'he, 7'h00, 6'h02, 6'h00, 4'h0, 1'b0);
    finish_test();
  end
endmodule : cht_horiz_timing_tb_top
`default_nettype wire

// ---- rtl/cht_horiz_timing.sv ----
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
module cht_horiz_timing
  import cht_pkg::*;
#(
  parameter int CNT_W = CNT_W_DEF
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic              wrStrobe,
  input  wire logic              rdStrobe,
  output logic      [DATA_W-1:0] rdData,
  output logic                   horizontalSyncOut,
  output logic                   displayEnable,
  output logic                   blankActive,
  output logic                   lineStart
);

  if (CNT_W < CNT_W_MIN) begin : g_chk
    $error("CNT_W too small for longest line phase");
  end

  typedef struct packed {
    logic [ACTIVE_FIELD_W-1:0] activeField;
    logic [BLANK_FIELD_W-1:0]  blankField;
    logic [START_FIELD_W-1:0]  startField;
    logic                      syncPol;
    logic [WIDTH_FIELD_W-1:0]  widthField;
    logic [CTRL_USED_W-1:0]    control;
    logic [DATA_W-1:0]         rdData;
    cht_phase_t                phase;
    logic [CNT_W-1:0]          pixCnt;
    logic [CNT_W-1:0]          activeLast;
    logic [CNT_W-1:0]          blankLast;
    logic [CNT_W-1:0]          syncBeg;
    logic [CNT_W-1:0]          syncEnd;
    logic                      syncOn;
    logic                      syncPin;
    logic                      dispEn;
    logic                      blank;
    logic                      lineStart;
  } cht_state_t;

  cht_state_t st_r;
  cht_state_t st_nxt;

  logic [CNT_W-1:0] calcActiveLast;
  logic [CNT_W-1:0] calcBlankLast;
  logic [CNT_W-1:0] calcSyncBeg;
  logic [CNT_W-1:0] calcSyncEnd;

  logic             runEn;
  logic             inSync;
  logic [15:0]      posWide;

  cht_span_calc #(
    .CNT_W (CNT_W)
  ) u_span (
    .clk         (clk),
    .rst         (rst),
    .activeField (st_r.activeField),
    .blankField  (st_r.blankField),
    .startField  (st_r.startField),
    .widthField  (st_r.widthField),
    .tvMode      (st_r.control[CTRL_TV_BIT]),
    .palMode     (st_r.control[CTRL_PAL_BIT]),
    .deepColour  (st_r.control[CTRL_DEEP_BIT]),
    .activeLast  (calcActiveLast),
    .blankLast   (calcBlankLast),
    .syncBeg     (calcSyncBeg),
    .syncEnd     (calcSyncEnd)
  );

  always_comb begin
    st_nxt  = st_r;
    runEn   = st_r.control[CTRL_ENABLE_BIT];
    inSync  = 1'b0;
    posWide = 16'(st_r.pixCnt);

    // Register writes
    if (wrStrobe) begin
      case (addr)
        OFS_ACTIVE_WIDTH: begin
          st_nxt.activeField = wrData[ACTIVE_FIELD_W-1:0];
        end
        OFS_BLANK_PERIOD: begin
          st_nxt.blankField = wrData[BLANK_FIELD_W-1:0];
        end
        OFS_SYNC_START: begin
          st_nxt.startField = wrData[START_FIELD_W-1:0];
        end
        OFS_SYNC_WID_POL: begin
          st_nxt.syncPol    = wrData[SYNC_POL_BIT];
          st_nxt.widthField = wrData[WIDTH_FIELD_W-1:0];
        end
        OFS_CONTROL: begin
          st_nxt.control = wrData[CTRL_USED_W-1:0];
        end
        default: begin
          st_nxt.control = st_r.control;
        end
      endcase
    end

    // Register reads, data valid only in the following cycle
    st_nxt.rdData = '0;
    if (rdStrobe) begin
      case (addr)
        OFS_ACTIVE_WIDTH: begin
          st_nxt.rdData = DATA_W'(st_r.activeField);
        end
        OFS_BLANK_PERIOD: begin
          st_nxt.rdData = DATA_W'(st_r.blankField);
        end
        OFS_SYNC_START: begin
          st_nxt.rdData = DATA_W'(st_r.startField);
        end
        OFS_SYNC_WID_POL: begin
          st_nxt.rdData = DATA_W'(st_r.widthField);
          st_nxt.rdData[SYNC_POL_BIT] = st_r.syncPol;
        end
        OFS_CONTROL: begin
          st_nxt.rdData = DATA_W'(st_r.control);
        end
        OFS_STATUS: begin
          st_nxt.rdData[STAT_BLANK_BIT] = st_r.blank;
          st_nxt.rdData[STAT_SYNC_BIT]  = st_r.syncOn;
          st_nxt.rdData[STAT_RUN_BIT]   = (st_r.phase != PH_IDLE);
        end
        OFS_POS_LOW: begin
          st_nxt.rdData = posWide[7:0];
        end
        OFS_POS_HIGH: begin
          st_nxt.rdData = posWide[15:8];
        end
        default: begin
          st_nxt.rdData = '0;
        end
      endcase
    end

    // Line counter
    st_nxt.lineStart = 1'b0;
    case (st_r.phase)
      PH_IDLE: begin
        // Spans follow the registers freely while stopped
        st_nxt.pixCnt     = '0;
        st_nxt.activeLast = calcActiveLast;
        st_nxt.blankLast  = calcBlankLast;
        st_nxt.syncBeg    = calcSyncBeg;
        st_nxt.syncEnd    = calcSyncEnd;
        if (runEn) begin
          st_nxt.phase     = PH_ACTIVE;
          st_nxt.lineStart = 1'b1;
        end
      end
      PH_ACTIVE: begin
        // RL14 active period first
        if (st_r.pixCnt == st_r.activeLast) begin
          st_nxt.pixCnt = '0;
          st_nxt.phase  = PH_BLANK;
        end else begin
          st_nxt.pixCnt = st_r.pixCnt + CNT_W'(1);
        end
      end
      PH_BLANK: begin
        // RL14 blanking then restart
        if (st_r.pixCnt == st_r.blankLast) begin
          st_nxt.pixCnt = '0;
          // While running, new span settings take effect only at a line edge, no torn lines
          st_nxt.activeLast = calcActiveLast;
          st_nxt.blankLast  = calcBlankLast;
          st_nxt.syncBeg    = calcSyncBeg;
          st_nxt.syncEnd    = calcSyncEnd;
          st_nxt.phase      = PH_ACTIVE;
          st_nxt.lineStart  = 1'b1;
        end else begin
          st_nxt.pixCnt = st_r.pixCnt + CNT_W'(1);
        end
      end
      default: begin
        st_nxt.phase  = PH_IDLE;
        st_nxt.pixCnt = '0;
      end
    endcase
    if (!runEn) begin
      st_nxt.phase     = PH_IDLE;
      st_nxt.lineStart = 1'b0;
    end

    // RL7 sync window inside blanking
    // RL6 a window past blanking end is cut off there
    if (st_r.phase == PH_BLANK) begin
      inSync = (st_r.pixCnt >= st_r.syncBeg) &&
               (st_r.pixCnt < st_r.syncEnd);
    end
    st_nxt.syncOn = inSync;
    // RL10 polarity select
    st_nxt.syncPin = st_r.syncPol ? inSync : !inSync;
    st_nxt.dispEn  = (st_r.phase == PH_ACTIVE);
    st_nxt.blank   = (st_r.phase == PH_BLANK);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r             <= '0;
      st_r.activeField <= RST_ACTIVE_WIDTH[ACTIVE_FIELD_W-1:0];
      st_r.blankField  <= RST_BLANK_PERIOD[BLANK_FIELD_W-1:0];
      st_r.startField  <= RST_SYNC_START[START_FIELD_W-1:0];
      st_r.syncPol     <= RST_SYNC_WID_POL[SYNC_POL_BIT];
      st_r.widthField  <= RST_SYNC_WID_POL[WIDTH_FIELD_W-1:0];
      st_r.control     <= RST_CONTROL[CTRL_USED_W-1:0];
      st_r.phase       <= PH_IDLE;
      st_r.syncPin     <= !RST_SYNC_WID_POL[SYNC_POL_BIT];
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdData            = st_r.rdData;
  assign horizontalSyncOut = st_r.syncPin;
  assign displayEnable     = st_r.dispEn;
  assign blankActive       = st_r.blank;
  assign lineStart         = st_r.lineStart;

endmodule : cht_horiz_timing
`default_nettype wire

// ---- rtl/cht_pkg.sv ----
// Contract
// RL1 - Active width is (field+1) times eight pixels
// RL2 - CRT blanking is (field+1) times eight pixels
// RL3 - NTSC blanking is field times eight plus six
// RL4 - PAL blanking is field times eight plus seven
// RL5 - Software keeps CRT blanking field at least three
// RL6 - Software keeps sync start plus width inside blanking
// RL7 - Sync start delayed from blanking start, 8-pixel units
// RL8 - CRT sync start field*8 plus 3 or 5
// RL9 - TV sync start (field+1)*8 minus 7 or 5
// RL10 - Polarity bit 7 one gives active-high sync
// RL11 - Software sets polarity zero for NTSC or PAL
// RL12 - Sync width is (field+1) times eight pixels
// RL13 - Software sets sync width zero for NTSC/PAL
// RL14 - Count line: active period, blanking, then restart
package cht_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W_DEF = 11;
  localparam int CNT_W_MIN = 11;

  localparam logic [7:0] OFS_ACTIVE_WIDTH = 8'h50;
  localparam logic [7:0] OFS_CONTROL      = 8'h51;
  localparam logic [7:0] OFS_BLANK_PERIOD = 8'h52;
  localparam logic [7:0] OFS_SYNC_START   = 8'h53;
  localparam logic [7:0] OFS_SYNC_WID_POL = 8'h54;
  localparam logic [7:0] OFS_STATUS       = 8'h55;
  localparam logic [7:0] OFS_POS_LOW      = 8'h5c;
  localparam logic [7:0] OFS_POS_HIGH     = 8'h5d;

  localparam int ACTIVE_FIELD_W = 7;
  localparam int BLANK_FIELD_W  = 6;
  localparam int START_FIELD_W  = 6;
  localparam int WIDTH_FIELD_W  = 4;
  localparam int SYNC_POL_BIT   = 7;

  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_TV_BIT     = 1;
  localparam int CTRL_PAL_BIT    = 2;
  localparam int CTRL_DEEP_BIT   = 3;
  localparam int CTRL_USED_W     = 4;

  localparam int STAT_BLANK_BIT  = 0;
  localparam int STAT_SYNC_BIT   = 1;
  localparam int STAT_RUN_BIT    = 2;

  localparam logic [7:0] RST_ACTIVE_WIDTH = 8'h00;
  localparam logic [7:0] RST_BLANK_PERIOD = 8'h00;
  localparam logic [7:0] RST_SYNC_START   = 8'h00;
  localparam logic [7:0] RST_SYNC_WID_POL = 8'h00;
  localparam logic [7:0] RST_CONTROL      = 8'h00;

  localparam int UNIT_SHIFT      = 3;
  localparam int BLANK_NTSC_ADD  = 6;
  localparam int BLANK_PAL_ADD   = 7;
  localparam int SYNC_CRT_ADD_LO = 3;
  localparam int SYNC_CRT_ADD_HI = 5;
  localparam int SYNC_TV_SUB_LO  = 7;
  localparam int SYNC_TV_SUB_HI  = 5;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_ACTIVE = 2'b01,
    PH_BLANK  = 2'b10
  } cht_phase_t;

endpackage : cht_pkg

// ---- rtl/cht_span_calc.sv ----
`timescale 1ns/1ps
`default_nettype none
module cht_span_calc
  import cht_pkg::*;
#(
  parameter int CNT_W = CNT_W_DEF
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [ACTIVE_FIELD_W-1:0] activeField,
  input  wire logic [BLANK_FIELD_W-1:0]  blankField,
  input  wire logic [START_FIELD_W-1:0]  startField,
  input  wire logic [WIDTH_FIELD_W-1:0]  widthField,
  input  wire logic                      tvMode,
  input  wire logic                      palMode,
  input  wire logic                      deepColour,
  output logic      [CNT_W-1:0]          activeLast,
  output logic      [CNT_W-1:0]          blankLast,
  output logic      [CNT_W-1:0]          syncBeg,
  output logic      [CNT_W-1:0]          syncEnd
);

  if (CNT_W < CNT_W_MIN) begin : g_chk
    $error("CNT_W too small for longest line phase");
  end

  typedef struct packed {
    logic [CNT_W-1:0] activeLast;
    logic [CNT_W-1:0] blankLast;
    logic [CNT_W-1:0] syncBeg;
    logic [CNT_W-1:0] syncEnd;
  } cht_span_t;

  cht_span_t s_r;
  cht_span_t s_nxt;

  logic [CNT_W-1:0] active8;
  logic [CNT_W-1:0] blank8;
  logic [CNT_W-1:0] start8;
  logic [CNT_W-1:0] width8;

  always_comb begin
    active8 = CNT_W'(activeField) << UNIT_SHIFT;
    blank8  = CNT_W'(blankField) << UNIT_SHIFT;
    start8  = CNT_W'(startField) << UNIT_SHIFT;
    width8  = (CNT_W'(widthField) + CNT_W'(1)) << UNIT_SHIFT;
    // RL1 active span
    s_nxt.activeLast = active8 + CNT_W'((1 << UNIT_SHIFT) - 1);
    // RL2 CRT blanking span
    s_nxt.blankLast = blank8 + CNT_W'((1 << UNIT_SHIFT) - 1);
    if (tvMode && palMode) begin
      // RL4 PAL blanking span
      s_nxt.blankLast = blank8 + CNT_W'(BLANK_PAL_ADD - 1);
    end else if (tvMode) begin
      // RL3 NTSC blanking span
      s_nxt.blankLast = blank8 + CNT_W'(BLANK_NTSC_ADD - 1);
    end
    // RL7 RL8 CRT sync start
    s_nxt.syncBeg = start8 + CNT_W'(deepColour ? SYNC_CRT_ADD_HI
                                               : SYNC_CRT_ADD_LO);
    if (tvMode) begin
      // RL9 TV sync start
      s_nxt.syncBeg = start8 + CNT_W'(1 << UNIT_SHIFT)
                      - CNT_W'(deepColour ? SYNC_TV_SUB_HI
                                          : SYNC_TV_SUB_LO);
    end
    // RL12 sync width
    s_nxt.syncEnd = s_nxt.syncBeg + width8;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign activeLast = s_r.activeLast;
  assign blankLast  = s_r.blankLast;
  assign syncBeg    = s_r.syncBeg;
  assign syncEnd    = s_r.syncEnd;

endmodule : cht_span_calc
`default_nettype wire
